// *** include/tlbplr_defs.vh ***
// Constants for the translation buffer with pseudo-LRU replacement
`ifndef TLBPLR_DEFS_VH
`define TLBPLR_DEFS_VH
`define TLBPLR_WAYS        4
`define TLBPLR_SETS        32
`define TLBPLR_VIRTUAL_SEGMENT_ID_W      24
`define TLBPLR_TAG_W       11
`define TLBPLR_PPN_W       20
`define TLBPLR_STORAGE_CONTROL_BITS_W      4
`define TLBPLR_PP_W        2
`define TLBPLR_LRU_RESET   3'h0
`define TLBPLR_ITLB_N      4
`define TLBPLR_SEG_MSB     31
`define TLBPLR_SEG_LSB     28
`define TLBPLR_TAG_MSB     27
`define TLBPLR_TAG_LSB     17
`define TLBPLR_SET_MSB     16
`define TLBPLR_SET_LSB     12
`define TLBPLR_EPN_LSB     12
`define TLBPLR_OFF_MSB     11
`endif

// *** hw/tlbplr_lookup.v ***
// Main translation buffer, pseudo-LRU and instruction-side buffer
// How it works
// - 128 entries, four ways, 32 sets
// - Only valid entries may match
// - Physical address is page number plus offset
// - Store to unchanged page raises store fault
// - Tag holds effective address bits 4 to 14
// - Lookup and fetch match need segment id and tag equal; invalidate needs tag only
// - Bits 15 to 19 only pick set
// - No matching way raises miss fault
// - Write chosen way or LRU way
// - LRU bit 0 tracks way pair
// - LRU bits 1 and 2 track way
// - State written with bit 0 rightmost
// - Victim chosen from LRU bits
// - Instruction buffer four fully associative entries, filled in turn
// - Instruction buffer flushed on any change
// - Instruction buffer refilled by hardware
// - Attribute and protection bits delivered on hit
`timescale 1ns/1ps
`include "tlbplr_defs.vh"
module tlbplr_lookup #(
   parameter VIRTUAL_SEGMENT_ID_W = `TLBPLR_VIRTUAL_SEGMENT_ID_W,
   parameter PPN_W  = `TLBPLR_PPN_W
) (
   core_clk,
   sys_rst,
   segRegWrite,
   segRegIndex,
   segRegData,
   lookupReq,
   lookupStore,
   lookupEa,
   lookupHit,
   physAddr,
   storageControlBits,
   pageProtectionBits,
   missFault,
   storeFault,
   fetchReq,
   fetchEa,
   fetchHit,
   fetchPhysAddr,
   fetchMiss,
   entryWrite,
   entryUseLru,
   entryWay,
   entryEa,
   entryValid,
   entryChanged,
   entryVsid,
   entryPpn,
   entryWimg,
   entryPp,
   pageInvalidate,
   invalidateEa,
   lruVictimWay
);
   input                      core_clk;
   input                      sys_rst;
   input                      segRegWrite;
   input  [3:0]               segRegIndex;
   input  [VIRTUAL_SEGMENT_ID_W-1:0]        segRegData;
   input                      lookupReq;
   input                      lookupStore;
   input  [31:0]              lookupEa;
   output                     lookupHit;
   output [31:0]              physAddr;
   output [`TLBPLR_STORAGE_CONTROL_BITS_W-1:0] storageControlBits;
   output [`TLBPLR_PP_W-1:0]  pageProtectionBits;
   output                     missFault;
   output                     storeFault;
   input                      fetchReq;
   input  [31:0]              fetchEa;
   output                     fetchHit;
   output [31:0]              fetchPhysAddr;
   output                     fetchMiss;
   input                      entryWrite;
   input                      entryUseLru;
   input  [1:0]               entryWay;
   input  [31:0]              entryEa;
   input                      entryValid;
   input                      entryChanged;
   input  [VIRTUAL_SEGMENT_ID_W-1:0]        entryVsid;
   input  [PPN_W-1:0]         entryPpn;
   input  [`TLBPLR_STORAGE_CONTROL_BITS_W-1:0] entryWimg;
   input  [`TLBPLR_PP_W-1:0]  entryPp;
   input                      pageInvalidate;
   input  [31:0]              invalidateEa;
   output [1:0]               lruVictimWay;

   reg                        lookupHit;
   reg    [31:0]              physAddr;
   reg    [`TLBPLR_STORAGE_CONTROL_BITS_W-1:0] storageControlBits;
   reg    [`TLBPLR_PP_W-1:0]  pageProtectionBits;
   reg                        missFault;
   reg                        storeFault;
   reg                        fetchHit;
   reg    [31:0]              fetchPhysAddr;
   reg                        fetchMiss;

   localparam NE = `TLBPLR_WAYS * `TLBPLR_SETS;

   reg                        valid_q [0:NE-1];
   reg                        chg_q   [0:NE-1];
   reg    [VIRTUAL_SEGMENT_ID_W-1:0]        virtual_segment_id_q  [0:NE-1];
   reg    [`TLBPLR_TAG_W-1:0] tag_q   [0:NE-1];
   reg    [PPN_W-1:0]         ppn_q   [0:NE-1];
   reg    [`TLBPLR_STORAGE_CONTROL_BITS_W-1:0] storage_control_bits_q [0:NE-1];
   reg    [`TLBPLR_PP_W-1:0]  pp_q    [0:NE-1];
   reg    [2:0]               lru_q   [0:`TLBPLR_SETS-1];
   // No reset, software loads segments before use
   reg    [VIRTUAL_SEGMENT_ID_W-1:0]        seg_q   [0:15];

   reg                        iValid_q [0:`TLBPLR_ITLB_N-1];
   reg    [19:0]              iEpn_q   [0:`TLBPLR_ITLB_N-1];
   reg    [PPN_W-1:0]         iPpn_q   [0:`TLBPLR_ITLB_N-1];
   reg    [1:0]               iNext_q;

   // Ea bit n (big-endian) is vector bit 31-n
   function [4:0] setOf;
      input [31:0] ea;
      begin
         setOf = ea[`TLBPLR_SET_MSB:`TLBPLR_SET_LSB];
      end
   endfunction

   function [3:0] segOf;
      input [31:0] ea;
      begin
         segOf = ea[`TLBPLR_SEG_MSB:`TLBPLR_SEG_LSB];
      end
   endfunction

   function [`TLBPLR_TAG_W-1:0] tagOf;
      input [31:0] ea;
      begin
         tagOf = ea[`TLBPLR_TAG_MSB:`TLBPLR_TAG_LSB];
      end
   endfunction

   function [11:0] offOf;
      input [31:0] ea;
      begin
         offOf = ea[`TLBPLR_OFF_MSB:0];
      end
   endfunction

   function [19:0] epnOf;
      input [31:0] ea;
      begin
         epnOf = ea[`TLBPLR_SEG_MSB:`TLBPLR_EPN_LSB];
      end
   endfunction

   function [2:0] lruNext;
      input [2:0] s;
      input [1:0] w;
      begin
         lruNext = s;
         lruNext[0] = ~w[1];
         if (w == 2'h0) lruNext[1] = 1'b1;
         if (w == 2'h1) lruNext[1] = 1'b0;
         if (w == 2'h2) lruNext[2] = 1'b1;
         if (w == 2'h3) lruNext[2] = 1'b0;
      end
   endfunction

   function [1:0] victimOf;
      input [2:0] s;
      begin
         if (s[0]) victimOf = s[2] ? 2'h3 : 2'h2;
         else      victimOf = s[1] ? 2'h1 : 2'h0;
      end
   endfunction

   // Combinational lookup of the data, fetch and invalidate addresses
   reg                        hitC;
   reg    [1:0]               hitWay;
   reg    [6:0]               hitIdx;
   reg                        fHitC;
   reg    [6:0]               fIdx;
   reg                        iHitC;
   reg    [PPN_W-1:0]         iPpnC;
   reg                        invHit;
   reg    [6:0]               invIdx;
   reg    [6:0]               lkRow;
   reg    [6:0]               feRow;
   reg    [6:0]               ivRow;
   integer                    k;
   always @* begin
      hitC = 1'b0;
      hitWay = 2'h0;
      hitIdx = 7'h00;
      fHitC = 1'b0;
      fIdx = 7'h00;
      invHit = 1'b0;
      invIdx = 7'h00;
      iHitC = 1'b0;
      iPpnC = {PPN_W{1'b0}};
      lkRow = 7'h00;
      feRow = 7'h00;
      ivRow = 7'h00;
      for (k = 0; k < `TLBPLR_WAYS; k = k + 1) begin
         lkRow = {setOf(lookupEa), k[1:0]};
         feRow = {setOf(fetchEa), k[1:0]};
         ivRow = {setOf(invalidateEa), k[1:0]};
         if (valid_q[lkRow] && virtual_segment_id_q[lkRow] == seg_q[segOf(lookupEa)] &&
             tag_q[lkRow] == tagOf(lookupEa)) begin
            hitC = 1'b1;
            hitWay = k[1:0];
            hitIdx = lkRow;
         end
         if (valid_q[feRow] && virtual_segment_id_q[feRow] == seg_q[segOf(fetchEa)] &&
             tag_q[feRow] == tagOf(fetchEa)) begin
            fHitC = 1'b1;
            fIdx = feRow;
         end
         if (valid_q[ivRow] && tag_q[ivRow] == tagOf(invalidateEa)) begin
            invHit = 1'b1;
            invIdx = ivRow;
         end
      end
      for (k = 0; k < `TLBPLR_ITLB_N; k = k + 1) begin
         if (iValid_q[k] && iEpn_q[k] == epnOf(fetchEa)) begin
            iHitC = 1'b1;
            iPpnC = iPpn_q[k];
         end
      end
   end

   wire [4:0] wrSet    = setOf(entryEa);
   // Victim taken from the state before this edge
   wire [1:0] wrWay    = entryUseLru ? victimOf(lru_q[wrSet]) : entryWay;
   wire [6:0] wrIdx    = {wrSet, wrWay};
   wire       iFlush   = segRegWrite | entryWrite | pageInvalidate;

   assign lruVictimWay = victimOf(lru_q[setOf(entryEa)]);

   integer i;
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (i = 0; i < NE; i = i + 1) begin
            valid_q[i] <= 1'b0;
         end
         for (i = 0; i < `TLBPLR_SETS; i = i + 1) begin
            lru_q[i] <= `TLBPLR_LRU_RESET;
         end
         for (i = 0; i < `TLBPLR_ITLB_N; i = i + 1) begin
            iValid_q[i] <= 1'b0;
         end
         iNext_q <= 2'h0;
         lookupHit <= 1'b0;
         physAddr <= 32'h00000000;
         storageControlBits <= 4'h0;
         pageProtectionBits <= 2'h0;
         missFault <= 1'b0;
         storeFault <= 1'b0;
         fetchHit <= 1'b0;
         fetchPhysAddr <= 32'h00000000;
         fetchMiss <= 1'b0;
      end else begin
         lookupHit <= 1'b0;
         missFault <= 1'b0;
         storeFault <= 1'b0;
         fetchHit <= 1'b0;
         fetchMiss <= 1'b0;
         if (segRegWrite) begin
            seg_q[segRegIndex] <= segRegData;
         end
         // Tag only, so another segment's entry can go; only the last matching way is cleared
         if (pageInvalidate && invHit) begin
            valid_q[invIdx] <= 1'b0;
         end
         if (lookupReq) begin
            if (hitC) begin
               if (lookupStore && !chg_q[hitIdx]) begin
                  storeFault <= 1'b1;
               end else begin
                  lookupHit <= 1'b1;
               end
               physAddr <= {ppn_q[hitIdx], offOf(lookupEa)};
               storageControlBits <= storage_control_bits_q[hitIdx];
               pageProtectionBits <= pp_q[hitIdx];
               lru_q[setOf(lookupEa)] <= lruNext(lru_q[setOf(lookupEa)],
                                                 hitWay);
            end else begin
               missFault <= 1'b1;
            end
         end
         if (entryWrite) begin
            valid_q[wrIdx] <= entryValid;
            chg_q[wrIdx] <= entryChanged;
            virtual_segment_id_q[wrIdx] <= entryVsid;
            tag_q[wrIdx] <= tagOf(entryEa);
            ppn_q[wrIdx] <= entryPpn;
            storage_control_bits_q[wrIdx] <= entryWimg;
            pp_q[wrIdx] <= entryPp;
            // update on write, wins over lookup
            lru_q[wrSet] <= lruNext(lru_q[wrSet], wrWay);
         end
         // A fetch in a flush cycle gets no answer
         if (iFlush) begin
            for (i = 0; i < `TLBPLR_ITLB_N; i = i + 1) begin
               iValid_q[i] <= 1'b0;
            end
         end else if (fetchReq) begin
            if (iHitC) begin
               fetchHit <= 1'b1;
               fetchPhysAddr <= {iPpnC, offOf(fetchEa)};
            end else if (fHitC) begin
               iValid_q[iNext_q] <= 1'b1;
               iEpn_q[iNext_q] <= epnOf(fetchEa);
               iPpn_q[iNext_q] <= ppn_q[fIdx];
               iNext_q <= iNext_q + 2'h1;
               fetchHit <= 1'b1;
               fetchPhysAddr <= {ppn_q[fIdx], offOf(fetchEa)};
            end else begin
               fetchMiss <= 1'b1;
            end
         end
      end
   end
endmodule

// *** test/tlbplr_lookup_asserts.sv ***
// Port checker for the translation buffer
`timescale 1ns/1ps
module tlbplr_chk (
   input logic        core_clk,
   input logic        sys_rst,
   input logic        lookupReq,
   input logic        lookupStore,
   input logic [31:0] lookupEa,
   input logic        lookupHit,
   input logic [31:0] physAddr,
   input logic        missFault,
   input logic        storeFault,
   input logic        fetchReq,
   input logic        fetchHit,
   input logic        fetchMiss
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_load;
      lookupReq && !lookupStore;
   endsequence
   sequence s_ans;
      lookupHit || missFault || storeFault;
   endsequence
   property p_answer;
      lookupReq |=> s_ans;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_quiet;
      !lookupReq |=> !(lookupHit || missFault || storeFault);
   endproperty
   a_quiet: assert property (p_quiet) else $error("stray answer");
   property p_one;
      $onehot0({lookupHit, missFault, storeFault});
   endproperty
   a_one: assert property (p_one) else $error("two answers");
   property p_load;
      s_load |=> !storeFault;
   endproperty
   a_load: assert property (p_load) else $error("load store fault");
   property p_off;
      lookupHit || storeFault |-> physAddr[11:0] == $past(lookupEa[11:0]);
   endproperty
   a_off: assert property (p_off) else $error("bad offset");
   property p_hold;
      !lookupHit && !storeFault |-> $stable(physAddr);
   endproperty
   a_hold: assert property (p_hold) else $error("address moved");
   property p_fq;
      !fetchReq |=> !(fetchHit || fetchMiss);
   endproperty
   a_fq: assert property (p_fq) else $error("stray fetch");
   property p_fx;
      !(fetchHit && fetchMiss);
   endproperty
   a_fx: assert property (p_fx) else $error("fetch hit and miss");
endmodule
bind tlbplr_lookup tlbplr_chk tlbplr_chk_i (.core_clk, .sys_rst,
   .lookupReq, .lookupStore, .lookupEa, .lookupHit, .physAddr,
   .missFault, .storeFault, .fetchReq, .fetchHit, .fetchMiss);

// *** test/tlbplr_cpu_model.sv ***
// Load/store and fetch unit model
`timescale 1ns/1ps
module tlbplr_cpu (
   input  logic        core_clk,
   output logic        lookupReq = 1'h0,
   output logic        lookupStore = 1'h0,
   output logic [31:0] lookupEa = 32'h0,
   output logic        fetchReq = 1'h0,
   output logic [31:0] fetchEa = 32'h0
);
   task automatic ld(input logic [31:0] ea, input logic st);
      @(posedge core_clk);
      lookupReq <= 1'h1;
      lookupStore <= st;
      lookupEa <= ea;
      @(posedge core_clk);
      lookupReq <= 1'h0;
      // Released bus flips, so stale values never match
      lookupEa <= ~ea;
      #1;
   endtask
   task automatic fe(input logic [31:0] ea);
      @(posedge core_clk);
      fetchReq <= 1'h1;
      fetchEa <= ea;
      @(posedge core_clk);
      fetchReq <= 1'h0;
      fetchEa <= ~ea;
      #1;
   endtask
endmodule

// *** test/tlbplr_tb.sv ***
// Self-checking bench for the translation buffer
`timescale 1ns/1ps
module tb;
   localparam logic [23:0] VA = 24'h5A5A5A;
   logic        core_clk = 1'h0, sys_rst = 1'h1;
   logic        segRegWrite = 1'h0, entryWrite = 1'h0, entryUseLru = 1'h0;
   logic        entryValid = 1'h0, entryChanged = 1'h0, pageInvalidate = 1'h0;
   logic [3:0]  segRegIndex = 4'h0, entryWimg = 4'h0;
   logic [1:0]  entryWay = 2'h0, entryPp = 2'h0;
   logic [23:0] segRegData = 24'h0, entryVsid = VA;
   logic [19:0] entryPpn = 20'h0;
   logic [31:0] entryEa = 32'h0, invalidateEa = 32'h0;
   wire         lookupReq, lookupStore, fetchReq, lookupHit, missFault;
   wire         storeFault, fetchHit, fetchMiss;
   wire  [31:0] lookupEa, fetchEa, physAddr, fetchPhysAddr;
   wire  [3:0]  storageControlBits;
   wire  [1:0]  pageProtectionBits, lruVictimWay;
   logic [2:0]  lq = 3'h0;
   int          failures = 0, checks_done = 0, cyc = 0;
   tlbplr_lookup tlbplr_lookup_i (.core_clk, .sys_rst, .segRegWrite,
      .segRegIndex, .segRegData, .lookupReq, .lookupStore, .lookupEa,
      .lookupHit, .physAddr, .storageControlBits, .pageProtectionBits,
      .missFault, .storeFault, .fetchReq, .fetchEa, .fetchHit,
      .fetchPhysAddr, .fetchMiss, .entryWrite, .entryUseLru, .entryWay,
      .entryEa, .entryValid, .entryChanged, .entryVsid, .entryPpn,
      .entryWimg, .entryPp, .pageInvalidate, .invalidateEa, .lruVictimWay);
   tlbplr_cpu tlbplr_cpu_i (.core_clk, .lookupReq, .lookupStore, .lookupEa,
      .fetchReq, .fetchEa);
   always #50 core_clk = ~core_clk;
   // Whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         print_verdict;
      end
   end
   task automatic print_verdict;
      $display("Checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] ea(input int s, t, x, o);
      return {s[3:0], t[10:0], x[4:0], o[11:0]};
   endfunction
   function automatic logic [2:0] upd(input logic [2:0] s, input int w);
      if (w < 2) return {s[2], w == 0, 1'h1};
      return {w == 2, s[1], 1'h0};
   endfunction
   function automatic int vic(input logic [2:0] s);
      return s[0] ? (s[2] ? 3 : 2) : (s[1] ? 1 : 0);
   endfunction
   task automatic seg(input logic [3:0] i, input logic [23:0] v);
      @(posedge core_clk);
      segRegWrite <= 1'h1;
      segRegIndex <= i;
      segRegData <= v;
      @(posedge core_clk);
      segRegWrite <= 1'h0;
   endtask
   // reference bit belongs to memory tables, kept by software
   task automatic wr(input int w, u, logic [31:0] a, input int v, c, p);
      @(posedge core_clk);
      entryWrite <= 1'h1;
      entryUseLru <= u[0];
      entryWay <= w[1:0];
      entryEa <= a;
      entryValid <= v[0];
      entryChanged <= c[0];
      entryPpn <= p[19:0];
      entryWimg <= p[3:0];
      entryPp <= p[5:4];
      @(posedge core_clk);
      entryWrite <= 1'h0;
      #1;
   endtask
   // Result code: 0 hit, 1 miss, 2 store fault
   task automatic look(input logic [31:0] a, input logic st, input int r);
      tlbplr_cpu_i.ld(a, st);
      chk(lookupHit, r == 0);
      chk(missFault, r == 1);
      chk(storeFault, r == 2);
   endtask
   task automatic t_hits;
      int w;
      int p;
      seg(4'h3, VA);
      // distinct tags, no page mapped twice
      for (int i = 0; i < 4; i++) begin
         wr(i, 0, ea(3, i + 1, 5, 0), 1, 1, 'hA0000 + i * 17);
         lq = upd(lq, i);
         chk(lruVictimWay, vic(lq));
      end
      for (int i = 0; i < 12; i++) begin
         w = (i ^ (i >> 2)) & 3;
         p = 'hA0000 + w * 17;
         look(ea(3, w + 1, 5, i * 273), 1'h0, 0);
         lq = upd(lq, w);
         chk(physAddr, (p << 12) | (i * 273));
         chk(storageControlBits, p & 15);
         chk(pageProtectionBits, (p >> 4) & 3);
         chk(lruVictimWay, vic(lq));
      end
   endtask
   task automatic t_miss;
      seg(4'h4, ~VA);
      look(ea(4, 1, 5, 0), 1'h0, 1);
      look(ea(3, 9, 5, 0), 1'h0, 1);
      look(ea(3, 1, 6, 0), 1'h0, 1);
      chk(lruVictimWay, vic(lq));
      wr(0, 0, ea(3, 9, 7, 0), 0, 1, 1);
      look(ea(3, 9, 7, 0), 1'h0, 1);
   endtask
   task automatic t_lruw;
      int v;
      v = vic(lq);
      wr(v ^ 1, 1, ea(3, 20, 5, 0), 1, 0, 'hB0000);
      lq = upd(lq, v);
      chk(lruVictimWay, vic(lq));
      look(ea(3, v + 1, 5, 0), 1'h0, 1);
      look(ea(3, 20, 5, 'h123), 1'h1, 2);
      chk(physAddr, 'hB0000123);
      look(ea(3, 20, 5, 0), 1'h0, 0);
      look(ea(3, (v ^ 2) + 1, 5, 0), 1'h1, 0);
      lq = upd(lq, v ^ 2);
      chk(lruVictimWay, vic(lq));
   endtask
   task automatic t_fetch;
      tlbplr_cpu_i.fe(ea(3, 20, 5, 'h456));
      chk(fetchHit, 1);
      chk(fetchPhysAddr, 'hB0000456);
      seg(4'h3, ~VA);
      tlbplr_cpu_i.fe(ea(3, 20, 5, 'h456));
      chk(fetchMiss, 1);
      seg(4'h3, VA);
      tlbplr_cpu_i.fe(ea(3, 20, 5, 'h789));
      chk(fetchPhysAddr, 'hB0000789);
      // Same page again, now served by the instruction buffer
      tlbplr_cpu_i.fe(ea(3, 20, 5, 'hABC));
      chk(fetchHit, 1);
      chk(fetchPhysAddr, 'hB0000ABC);
      @(posedge core_clk);
      pageInvalidate <= 1'h1;
      invalidateEa <= ea(3, 20, 5, 0);
      @(posedge core_clk);
      pageInvalidate <= 1'h0;
      tlbplr_cpu_i.fe(ea(3, 20, 5, 'h456));
      chk(fetchMiss, 1);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      chk({lookupHit, missFault, storeFault, fetchHit, fetchMiss}, 0);
      sys_rst <= 1'h0;
      t_hits;
      t_miss;
      t_lruw;
      t_fetch;
      print_verdict;
   end
endmodule
